/* core/lag_filter.sv */
// first-order lag filter for the torque reference
// assumes a signed 16-bit reference on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "servo_speed_limit_regs.svh"
module lag_filter (
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst,
    // settings
    input  wire logic [15:0]        timeConst,
    // data
    input  wire logic signed [15:0] torqueIn,
    output logic signed [15:0]      torqueOut
);
    localparam int STEP = `TC_STEP_CYCLES;
    logic [11:0]        stepCount;
    logic signed [47:0] acc;
    logic signed [47:0] diff;
    logic               stepTick;

    // one filter update per 0.01 ms time unit
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stepCount <= 12'h000;
        end else if (stepCount == 12'(STEP - 1)) begin
            stepCount <= 12'h000;
        end else begin
            stepCount <= stepCount + 12'h001;
        end
    end
    assign stepTick = (stepCount == 12'(STEP - 1));
    assign diff = ({{16{torqueIn[15]}}, torqueIn, 16'h0000} - acc);

    // acc += diff/(tc+1); tc of 0 passes straight through, tracking new value
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            acc <= 48'sh0;
        end else if (timeConst == 16'h0000) begin
            acc <= {{16{torqueIn[15]}}, torqueIn, 16'h0000};
        end else if (stepTick) begin
            // divider is costly but tc changes take effect at once, no table
            acc <= acc + diff / $signed({32'h0, timeConst} + 48'h1);
        end
    end
    assign torqueOut = acc[31:16];
endmodule
`default_nettype wire

/* core/servo_speed_limit.sv */
// speed limit, torque filter and preset speed select for a servo amplifier
// assumes discrete inputs are asynchronous pins, speed values are synchronous
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "servo_speed_limit_regs.svh"
module servo_speed_limit
    import servo_speed_limit_pkg::*;
(
    // clock and reset
    input  wire logic                         sys_clk,
    input  wire logic                         rst,
    // register port
    input  wire servo_speed_limit_pkg::regaddr_t regAddr,
    input  wire logic [31:0]                  regWdata,
    input  wire logic                         regWrite,
    input  wire logic                         regRead,
    output logic [31:0]                       regRdata,
    // discrete inputs, active high means on (closed)
    input  wire logic                         proportional_ctrl_in,
    input  wire logic                         forward_current_limit_in,
    input  wire logic                         reverse_current_limit_in,
    input  wire logic                         direction_select_in,
    input  wire logic                         speed_select_a_in,
    input  wire logic                         speed_select_b_in,
    // analog and feedback, sampled values on sys_clk
    input  wire logic signed [15:0]           torqueRef,
    input  wire logic signed [15:0]           extLimitVolt,
    input  wire logic signed [15:0]           motorSpeed,
    // outputs
    output logic signed [15:0]                torqueCmd,
    output logic signed [15:0]                speedCmd,
    output logic                              speed_limit_active_out,
    output logic                              clampActive,
    output logic [15:0]                       effectiveLimit
);
    import servo_speed_limit_pkg::*;
    localparam int SELP = `SEL_PERIOD_CYCLES;

    setting_t   torque_filter_time_constant;
    setting_t   internal_speed_limit;
    setting_t   speed_input_gain;
    setting_t   preset_speed_one;
    setting_t   preset_speed_two;
    setting_t   preset_speed_three;
    speed_t     motorMax;
    speed_t     overspeedLevel;
    speed_t     ratedSpeed;
    logic [9:0] modeReg;
    logic       speed_limit_source_select;
    logic       limit_ceiling_select;
    logic [3:0] control_method_select;
    logic [5:0] pinMeta;
    logic [5:0] pinSync;
    logic [2:0] pinSel;
    logic [18:0] selCount;
    logic       selTick;
    logic       dirLatched;
    speed_sel_e selLatched;
    speed_t     ceiling, intLimit, extLimit, next_limit;
    speed_t     speedMag, presetRaw, presetCap;
    logic [31:0] extProd;
    logic [15:0] voltMag;
    logic       limitHit;

    // settings registers; out-of-range writes are clipped to the legal span
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            torque_filter_time_constant <= `RST_FILTER_TC;
            internal_speed_limit        <= `RST_LIMIT_INT;
            speed_input_gain            <= `RST_INPUT_GAIN;
            preset_speed_one            <= `RST_PRESET_ONE;
            preset_speed_two            <= `RST_PRESET_TWO;
            preset_speed_three          <= `RST_PRESET_THREE;
            motorMax                    <= `RST_MOTOR_MAX;
            overspeedLevel              <= `RST_OVERSPEED;
            ratedSpeed                  <= `RST_RATED;
            modeReg                     <= 10'h000;
        end else if (regWrite) begin
            case (regAddr)
                `REG_FILTER_TC: begin
                    torque_filter_time_constant <= regWdata[15:0];
                end
                `REG_MODE:         modeReg <= regWdata[9:0];
                `REG_LIMIT_INT: begin
                    internal_speed_limit <= clipLimit(regWdata[15:0]);
                end
                `REG_INPUT_GAIN: begin
                    if (regWdata[15:0] < `GAIN_MIN) begin
                        speed_input_gain <= `GAIN_MIN;
                    end else if (regWdata[15:0] > `GAIN_MAX) begin
                        speed_input_gain <= `GAIN_MAX;
                    end else begin
                        speed_input_gain <= regWdata[15:0];
                    end
                end
                `REG_PRESET_ONE: begin
                    preset_speed_one <= clipLimit(regWdata[15:0]);
                end
                `REG_PRESET_TWO: begin
                    preset_speed_two <= clipLimit(regWdata[15:0]);
                end
                `REG_PRESET_THREE: begin
                    preset_speed_three <= clipLimit(regWdata[15:0]);
                end
                `REG_MOTOR_MAX:    motorMax <= regWdata[15:0];
                `REG_OVERSPEED:    overspeedLevel <= regWdata[15:0];
                `REG_RATED:        ratedSpeed <= regWdata[15:0];
                default: ;
            endcase
        end
    end

    function automatic setting_t clipLimit(input setting_t v);
        clipLimit = (v > `LIMIT_MAX) ? `LIMIT_MAX : v;
    endfunction

    // restart-enabled selections copy the mode register only on restart
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            speed_limit_source_select <= 1'b0;
            limit_ceiling_select      <= 1'b0;
            control_method_select     <= 4'h0;
        end else if (regWrite && regAddr == `REG_RESTART) begin
            speed_limit_source_select <= modeReg[`MODE_SRC_BIT];
            limit_ceiling_select      <= modeReg[`MODE_CEIL_BIT];
            control_method_select     <= modeReg[`MODE_CTRL_LSB +: 4];
        end
    end

    // read data one cycle after the read strobe, zero otherwise
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            regRdata <= 32'h0;
        end else if (regRead) begin
            case (regAddr)
                `REG_FILTER_TC:    regRdata <= {16'h0, torque_filter_time_constant};
                `REG_MODE:         regRdata <= {22'h0, modeReg};
                `REG_LIMIT_INT:    regRdata <= {16'h0, internal_speed_limit};
                `REG_INPUT_GAIN:   regRdata <= {16'h0, speed_input_gain};
                `REG_PRESET_ONE:   regRdata <= {16'h0, preset_speed_one};
                `REG_PRESET_TWO:   regRdata <= {16'h0, preset_speed_two};
                `REG_PRESET_THREE: regRdata <= {16'h0, preset_speed_three};
                `REG_MOTOR_MAX:    regRdata <= {16'h0, motorMax};
                `REG_OVERSPEED:    regRdata <= {16'h0, overspeedLevel};
                `REG_RATED:        regRdata <= {16'h0, ratedSpeed};
                `REG_STATUS:       regRdata <= {effectiveLimit, 8'h0,
                                    control_method_select, 1'b0,
                                    dirLatched, speed_limit_active_out,
                                    speed_limit_source_select};
                `REG_TORQUE_OUT:   regRdata <= {16'h0, torqueCmd};
                default:           regRdata <= 32'h0;
            endcase
        end else begin
            regRdata <= 32'h0;
        end
    end

    // torque reference smoothing
    lag_filter u_filter (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .timeConst (torque_filter_time_constant),
        .torqueIn  (torqueRef),
        .torqueOut (torqueCmd)
    );

    // two-flop synchroniser on all pins, allocation mux only after it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pinMeta <= 6'h00;
            pinSync <= 6'h00;
        end else begin
            pinMeta <= {direction_select_in, speed_select_a_in,
                        speed_select_b_in, proportional_ctrl_in,
                        forward_current_limit_in, reverse_current_limit_in};
            pinSync <= pinMeta;
        end
    end
    assign pinSel = modeReg[`MODE_ALT_BIT] ? pinSync[5:3]
                                           : pinSync[2:0];

    // selects load once per short period, well inside the 2 ms bound
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            selCount <= 19'h0;
        end else if (selTick) begin
            selCount <= 19'h0;
        end else begin
            selCount <= selCount + 19'h1;
        end
    end
    assign selTick = (selCount == 19'(SELP - 1));

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dirLatched <= 1'b0;
            selLatched <= SEL_STOP;
        end else if (selTick) begin
            dirLatched <= pinSel[2];
            selLatched <= speed_sel_e'(pinSel[1:0]);
        end
    end

    // preset choice and motor max cap; direct drive uses 0.1 rpm units
    always_comb begin
        case (selLatched)
            SEL_STOP:  presetRaw = 16'h0000;
            SEL_ONE:   presetRaw = preset_speed_one;
            SEL_TWO:   presetRaw = preset_speed_two;
            SEL_THREE: presetRaw = preset_speed_three;
            default:   presetRaw = 16'h0000;
        endcase
        // direct drive words are 0.1 rpm, so motor max is scaled to match
        if (modeReg[`MODE_DD_BIT]) begin
            presetCap = (presetRaw > 16'(motorMax * 16'd10)) ?
                        16'(motorMax * 16'd10) : presetRaw;
        end else begin
            presetCap = (presetRaw > motorMax) ? motorMax : presetRaw;
        end
    end

    // signed preset command; off direction means forward
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            speedCmd <= 16'sh0;
        end else if (control_method_select == `CTRL_INTERNAL_SET) begin
            speedCmd <= dirLatched ? -$signed(presetCap)
                                   : $signed(presetCap);
        end else begin
            speedCmd <= 16'sh0;
        end
    end

    // limit path: ceiling, internal, and magnitude-scaled analog limit
    always_comb begin
        ceiling  = limit_ceiling_select ? overspeedLevel : motorMax;
        intLimit = (internal_speed_limit < ceiling) ?
                   internal_speed_limit : ceiling;
        voltMag  = extLimitVolt[15] ? 16'(-extLimitVolt)
                                    : extLimitVolt;
        // voltage in 0.01 V units; speed = v * rated / gain
        extProd  = (32'(voltMag) * 32'(ratedSpeed)) / 32'(speed_input_gain);
        // saturate so a large voltage never wraps into a small limit
        extLimit = (extProd > 32'h0000ffff) ? 16'hffff : extProd[15:0];
        if (speed_limit_source_select) begin
            next_limit = (extLimit < intLimit) ? extLimit : intLimit;
        end else begin
            next_limit = intLimit;
        end
        speedMag = motorSpeed[15] ? 16'(-motorSpeed) : motorSpeed;
    end
    assign limitHit = (speedMag >= effectiveLimit);

    // effective limit and limit status registered for glitch-free output
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            effectiveLimit         <= `RST_LIMIT_INT;
            speed_limit_active_out <= 1'b0;
            clampActive            <= 1'b0;
        end else begin
            effectiveLimit         <= next_limit;
            speed_limit_active_out <= limitHit;
            clampActive            <= limitHit &&
                control_method_select != `CTRL_INTERNAL_SET;
        end
    end

    // assertions
    property p_limit_status;
        @(posedge sys_clk) disable iff (rst)
        limitHit |=> speed_limit_active_out;
    endproperty
    a_limit_status: assert property (p_limit_status)
        else $error("limit status not raised");
    property p_limit_off;
        @(posedge sys_clk) disable iff (rst)
        !limitHit |=> !speed_limit_active_out;
    endproperty
    a_limit_off: assert property (p_limit_off)
        else $error("limit status stuck on");
    property p_ext_min;
        @(posedge sys_clk) disable iff (rst)
        speed_limit_source_select |=> effectiveLimit <= $past(intLimit);
    endproperty
    a_ext_min: assert property (p_ext_min)
        else $error("external limit above internal");
    // the edge that ends reset still loads the reset limit, so skip it
    property p_ceiling;
        @(posedge sys_clk) disable iff (rst)
        !rst |=> effectiveLimit <= $past(ceiling);
    endproperty
    a_ceiling: assert property (p_ceiling)
        else $error("limit above ceiling");
    sequence s_stop_sel;
        selLatched == SEL_STOP && control_method_select == `CTRL_INTERNAL_SET;
    endsequence
    property p_stop;
        @(posedge sys_clk) disable iff (rst)
        s_stop_sel |=> speedCmd == 16'sh0;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop selection not zero");
    property p_gain_range;
        @(posedge sys_clk) disable iff (rst)
        speed_input_gain >= `GAIN_MIN && speed_input_gain <= `GAIN_MAX;
    endproperty
    a_gain_range: assert property (p_gain_range)
        else $error("gain out of range");
    property p_sel_hold;
        @(posedge sys_clk) disable iff (rst)
        !selTick |=> $stable(selLatched);
    endproperty
    a_sel_hold: assert property (p_sel_hold)
        else $error("select changed off tick");
    property p_sel_period;
        @(posedge sys_clk) disable iff (rst)
        selTick |=> !selTick;
    endproperty
    a_sel_period: assert property (p_sel_period)
        else $error("select tick too frequent");
endmodule
`default_nettype wire

/* core/servo_speed_limit_pkg.sv */
// types shared by the speed limit block
// assumes the constants header is included where numbers are needed
package servo_speed_limit_pkg;
    typedef logic [15:0] speed_t;
    typedef logic [15:0] setting_t;
    typedef logic [7:0]  regaddr_t;
    typedef enum logic [1:0] {
        SEL_STOP  = 2'b00,
        SEL_ONE   = 2'b01,
        SEL_TWO   = 2'b11,
        SEL_THREE = 2'b10
    } speed_sel_e;
endpackage

/* core/servo_speed_limit_regs.svh */
// offsets, field positions, reset values and timing counts for the
// speed limit / preset speed block; definitions only
`ifndef SERVO_SPEED_LIMIT_REGS_SVH
`define SERVO_SPEED_LIMIT_REGS_SVH

// register word addresses on the plain register port
`define REG_FILTER_TC      8'h00
`define REG_MODE           8'h04
`define REG_LIMIT_INT      8'h08
`define REG_INPUT_GAIN     8'h0c
`define REG_PRESET_ONE     8'h10
`define REG_PRESET_TWO     8'h14
`define REG_PRESET_THREE   8'h18
`define REG_MOTOR_MAX      8'h1c
`define REG_OVERSPEED      8'h20
`define REG_RATED          8'h24
`define REG_STATUS         8'h28
`define REG_RESTART        8'h2c
`define REG_TORQUE_OUT     8'h30

// mode register fields
`define MODE_SRC_BIT       0
`define MODE_CEIL_BIT      1
`define MODE_CTRL_LSB      4
`define MODE_ALT_BIT       8
`define MODE_DD_BIT        9

// reset values
`define RST_FILTER_TC      16'h0000
`define RST_LIMIT_INT      16'h2710
`define RST_INPUT_GAIN     16'h0258
`define RST_PRESET_ONE     16'h0064
`define RST_PRESET_TWO     16'h00c8
`define RST_PRESET_THREE   16'h012c
`define RST_MOTOR_MAX      16'h1770
`define RST_OVERSPEED      16'h1b58
`define RST_RATED          16'h0bb8

// setting ranges
`define LIMIT_MAX          16'h2710
`define GAIN_MIN           16'h0096
`define GAIN_MAX           16'h0bb8
`define CTRL_INTERNAL_SET  4'h3

// filter step of 0.01 ms at 250 MHz; selects sampled every 4 us, so the
// load plus synchroniser delay stays well inside its 2 ms bound
`define TC_STEP_NS         10000
`define CLK_PERIOD_NS      4
`define TC_STEP_CYCLES     (`TC_STEP_NS / `CLK_PERIOD_NS)
`define SEL_PERIOD_NS      4000
`define SEL_PERIOD_CYCLES  (`SEL_PERIOD_NS / `CLK_PERIOD_NS)

`endif

/* testbench/host_model.sv */
// host controller model: drives the discrete pins and analog values
// assumes its tasks are called from a process that follows sys_clk
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // clock
    input  wire logic          sys_clk,
    // factory pins, high = on
    output logic               proportional_ctrl_in,
    output logic               forward_current_limit_in,
    output logic               reverse_current_limit_in,
    // alternate pins, high = on
    output logic               direction_select_in,
    output logic               speed_select_a_in,
    output logic               speed_select_b_in,
    // analog and feedback
    output logic signed [15:0] torqueRef,
    output logic signed [15:0] extLimitVolt,
    output logic signed [15:0] motorSpeed
);
    // everything idle at time zero
    initial begin
        {proportional_ctrl_in, forward_current_limit_in} = 2'b00;
        {reverse_current_limit_in, direction_select_in} = 2'b00;
        {speed_select_a_in, speed_select_b_in} = 2'b00;
        torqueRef = 16'sh0000;
        extLimitVolt = 16'sh0000;
        motorSpeed = 16'sh0000;
    end

    // index 0 stop, 1 off/on, 2 on/on, 3 on/off; unused set gets the
    // inverse so a wrong pin mux cannot pass by accident
    task automatic setPreset(input logic rev, input logic [1:0] idx,
                             input logic alt);
        logic a;
        logic b;
        a = (idx == 2'd2) || (idx == 2'd3);
        b = (idx == 2'd1) || (idx == 2'd2);
        @(posedge sys_clk);
        if (alt) begin
            direction_select_in <= rev;
            speed_select_a_in <= a;
            speed_select_b_in <= b;
            proportional_ctrl_in <= ~rev;
            forward_current_limit_in <= ~a;
            reverse_current_limit_in <= ~b;
        end else begin
            proportional_ctrl_in <= rev;
            forward_current_limit_in <= a;
            reverse_current_limit_in <= b;
            direction_select_in <= ~rev;
            speed_select_a_in <= ~a;
            speed_select_b_in <= ~b;
        end
    endtask

    // analog samples change together just after an edge
    task automatic setAnalog(input logic signed [15:0] t,
                             input logic signed [15:0] v,
                             input logic signed [15:0] s);
        @(posedge sys_clk);
        torqueRef <= t;
        extLimitVolt <= v;
        motorSpeed <= s;
    endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the speed limit block over its register port
// assumes the host model drives pins; select loads are awaited by polling
`timescale 1ns/1ps
`default_nettype none
`include "servo_speed_limit_regs.svh"
module tb_top;
    import servo_speed_limit_pkg::*;
    logic               sys_clk = 1'b0;
    logic               rst = 1'b1;
    regaddr_t           regAddr = 8'h00;
    logic [31:0]        regWdata = 32'h0;
    logic               regWrite = 1'b0;
    logic               regRead = 1'b0;
    logic [31:0]        regRdata, rdVal;
    logic               pCtl, fwdLim, revLim, dirSel, selA, selB;
    logic signed [15:0] torqueRef, extLimitVolt, motorSpeed;
    logic signed [15:0] torqueCmd, speedCmd;
    logic               limitOut, clampActive;
    logic [15:0]        effectiveLimit;
    int                 failCount = 0;
    int                 cmpCount = 0;

    always #2 sys_clk = ~sys_clk;

    host_model host_model_i (.sys_clk(sys_clk),
        .proportional_ctrl_in(pCtl), .forward_current_limit_in(fwdLim),
        .reverse_current_limit_in(revLim), .direction_select_in(dirSel),
        .speed_select_a_in(selA), .speed_select_b_in(selB),
        .torqueRef(torqueRef), .extLimitVolt(extLimitVolt),
        .motorSpeed(motorSpeed));
    servo_speed_limit servo_speed_limit_i (.sys_clk(sys_clk), .rst(rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata),
        .proportional_ctrl_in(pCtl), .forward_current_limit_in(fwdLim),
        .reverse_current_limit_in(revLim), .direction_select_in(dirSel),
        .speed_select_a_in(selA), .speed_select_b_in(selB),
        .torqueRef(torqueRef), .extLimitVolt(extLimitVolt),
        .motorSpeed(motorSpeed), .torqueCmd(torqueCmd),
        .speedCmd(speedCmd), .speed_limit_active_out(limitOut),
        .clampActive(clampActive), .effectiveLimit(effectiveLimit));

    task automatic finishTest();
        $display("comparisons %0d mismatches %0d", cmpCount, failCount);
        if (failCount == 0 && cmpCount > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic checkWord(input string what, input logic [31:0] exp,
                             input logic [31:0] got);
        cmpCount++;
        if (got !== exp) begin
            failCount++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic checkBit(input string what, input logic exp,
                            input logic got);
        cmpCount++;
        if (got !== exp) begin
            failCount++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    // one-cycle write strobe beside address and data
    task automatic regWr(input regaddr_t a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe edge
    task automatic expectReg(input regaddr_t a, input logic [31:0] mask,
                             input logic [31:0] exp);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1 rdVal = regRdata;
        checkWord("regRdata", exp, rdVal & mask);
    endtask

    function automatic logic [15:0] probe(input int which);
        case (which)
            0: return effectiveLimit;
            1: return torqueCmd;
            default: return speedCmd;
        endcase
    endfunction

    // bounded poll 1 ns after each edge, where outputs have settled;
    // the bound covers one select period; running out fails the compare
    task automatic waitFor(input int which, input logic [15:0] exp);
        int n;
        #1;
        for (n = 0; n < 1100 && probe(which) !== exp; n++) begin
            @(posedge sys_clk);
            #1;
        end
        checkWord(which == 0 ? "effectiveLimit" :
                  which == 1 ? "torqueCmd" : "speedCmd",
                  {16'h0, exp}, {16'h0, probe(which)});
    endtask

    // speed feedback change, then limit flags after the one-cycle lag
    task automatic speedFlags(input logic signed [15:0] s, input logic act,
                              input logic clamp);
        host_model_i.setAnalog(16'sh0000, 16'sh0000, s);
        repeat (3) @(posedge sys_clk);
        #1 checkBit("speed_limit_active_out", act, limitOut);
        checkBit("clampActive", clamp, clampActive);
    endtask

    initial begin
        #200000 failCount++;
        finishTest();
    end

    initial begin
        regaddr_t    addrs [6] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
        logic [31:0] dflt [6] = '{32'h0, 32'h2710, 32'h258, 32'h64,
                                  32'hc8, 32'h12c};
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        // defaults, then an unmapped address reads zero
        for (int i = 0; i < 6; i++) begin
            expectReg(addrs[i], '1, dflt[i]);
        end
        expectReg(8'h40, '1, 32'h0);
        waitFor(0, 16'd6000);
        // out-of-range settings clip, writes and reads back to back
        regWr(8'h08, 32'd20000);
        expectReg(8'h08, '1, 32'd10000);
        regWr(8'h0c, 32'd100);
        expectReg(8'h0c, '1, 32'd150);
        regWr(8'h0c, 32'd4000);
        expectReg(8'h0c, '1, 32'd3000);
        regWr(8'h10, 32'd12000);
        expectReg(8'h10, '1, 32'd10000);
        // outside method 3 the preset command stays at zero
        host_model_i.setPreset(1'b0, 2'd1, 1'b0);
        waitFor(2, 16'd0);
        // internal limit, both directions of rotation
        regWr(8'h08, 32'd2000);
        waitFor(0, 16'd2000);
        speedFlags(16'sd1999, 1'b0, 1'b0);
        speedFlags(16'sd2000, 1'b1, 1'b1);
        expectReg(8'h28, 32'hffff0003, {16'd2000, 16'h0002});
        speedFlags(-16'sd2000, 1'b1, 1'b1);
        speedFlags(16'sd0, 1'b0, 1'b0);
        // ceiling select takes hold only at restart
        regWr(8'h08, 32'd10000);
        regWr(8'h04, 32'h2);
        waitFor(0, 16'd6000);
        regWr(8'h2c, 32'h1);
        waitFor(0, 16'd7000);
        // external source: |v| * rated / gain, min with internal
        regWr(8'h04, 32'h1);
        regWr(8'h2c, 32'h1);
        regWr(8'h0c, 32'd600);
        host_model_i.setAnalog(16'sh0000, 16'sd300, 16'sh0000);
        waitFor(0, 16'd1500);
        expectReg(8'h28, 32'h1, 32'h1);
        host_model_i.setAnalog(16'sh0000, -16'sd300, 16'sh0000);
        waitFor(0, 16'd1500);
        regWr(8'h0c, 32'd300);
        waitFor(0, 16'd3000);
        regWr(8'h08, 32'd1000);
        waitFor(0, 16'd1000);
        // filter passes through at zero and lags otherwise
        host_model_i.setAnalog(16'sd1234, 16'sh0000, 16'sh0000);
        waitFor(1, 16'd1234);
        regWr(8'h00, 32'd5);
        host_model_i.setAnalog(16'sd2000, 16'sh0000, 16'sh0000);
        repeat (4) @(posedge sys_clk);
        #1 checkBit("torqueLag", 1'b1, torqueCmd !== 16'sd2000);
        // method 3 after restart; no torque-mode clamp there
        regWr(8'h08, 32'd10000);
        regWr(8'h04, 32'h30);
        regWr(8'h2c, 32'h1);
        expectReg(8'h28, 32'hf0, 32'h30);
        waitFor(0, 16'd6000);
        speedFlags(16'sd6000, 1'b1, 1'b0);
        // presets: motor max cap, reverse, alternate pins, direct drive
        host_model_i.setPreset(1'b0, 2'd1, 1'b0);
        waitFor(2, 16'd6000);
        host_model_i.setPreset(1'b1, 2'd2, 1'b0);
        waitFor(2, -16'sd200);
        regWr(8'h04, 32'h130);
        host_model_i.setPreset(1'b0, 2'd3, 1'b1);
        waitFor(2, 16'd300);
        regWr(8'h04, 32'h330);
        host_model_i.setPreset(1'b0, 2'd1, 1'b1);
        waitFor(2, 16'd10000);
        host_model_i.setPreset(1'b0, 2'd0, 1'b1);
        waitFor(2, 16'd0);
        finishTest();
    end
endmodule
`default_nettype wire
